// ### hdl/freq_counter.v
// Purpose: frequency and duty-cycle counter with window comparator controls
// Assumes: analog comparator outputs arrive as asynchronous levels
// Notes:   cycle counter advances on sampled rising edges of the test signal
//
// Summary of operation
// - Three 24-bit counters, each three readable bytes
// - Gate/high count clock; cycle counts signal edges
// - Source bit5: 0 comparator, 1 external pin
// - Disabled clears gate low, cycle, high, overflow
// - Gate upper bytes writable only while disabled
// - Start at edge, run to overflow, stop edge
// - Done event raised when counting stops
// - Cycle counter holds whole periods measured
// - High counter holds clocks signal was high
// - Cycle overflow sets sticky flag bit3
// - Counter bytes at 0x4C upward, MSB first
// - Bit6 switches window comparator on
// - Live window/high/low status in bits 3..1
// - Threshold select fields, high 7:4, low 3:0
// - Input select field bits 7:5
// - Bit4 picks window or multi-function output
// - High and low outputs form window output
//
// The strobed register port was left to the implementer.

`include "freq_counter_regs.vh"

module freq_counter #(
    parameter CW = 24
) (
    // Clock and reset
    input  wire       core_clk,
    input  wire       reset_n,
    // Register port
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // Signals from outside the clock domain
    input  wire       ext_count_input,
    input  wire       high_cmp_raw,
    input  wire       low_cmp_raw,
    input  wire       multifunc_cmp_out,
    // Analog comparator controls
    output wire       window_enable,
    output wire [3:0] high_threshold_sel,
    output wire [3:0] low_threshold_sel,
    output wire [2:0] window_input_sel,
    // Interrupt requests
    output wire       measure_done_irq,
    output wire       window_irq
);

    // Control registers
    reg  [7:0]    int_enable_0_q;
    reg  [7:0]    int_enable_2_q;
    reg           measure_done_flag_q;
    reg           window_out_flag_q;
    reg           high_out_flag_q;
    reg           low_out_flag_q;
    reg           cycle_overflow_flag_q;
    reg  [7:0]    power_control_1_q;
    reg  [7:0]    threshold_select_q;
    reg  [2:0]    window_input_sel_q;
    reg           meas_cmp_source_sel_q;
    // Counters and measurement state
    reg  [CW-1:0] gate_counter_q;
    reg  [CW-1:0] cycle_counter_q;
    reg  [CW-1:0] high_time_counter_q;
    reg  [1:0]    meas_state_q;
    reg  [1:0]    meas_state_d;
    // Synchronisers and edge state
    reg  [3:0]    sync1_q;
    reg  [3:0]    sync2_q;
    reg           test_prev_q;
    reg           window_out_q;
    reg           window_prev_q;
    reg           high_prev_q;
    reg           low_prev_q;

    wire          wr_en;
    wire          counter_enable;
    wire          counter_source_sel;
    wire          global_irq_enable;
    wire          high_cmp_out;
    wire          low_cmp_out;
    wire          ext_sync;
    wire          mfc_sync;
    wire          meas_cmp_signal;
    wire          test_signal;
    wire          test_rise;
    wire          gate_wrap;
    wire          cycle_wrap;
    wire          stop_now;
    wire          running;
    wire          gate_done;
    wire          window_change;
    wire          high_change;
    wire          low_change;
    wire [CW:0]   gate_sum;
    wire [CW:0]   cycle_sum;

    // Measurement states
    localparam [1:0] ST_STOP  = 2'h0;
    localparam [1:0] ST_ARMED = 2'h1;
    localparam [1:0] ST_COUNT = 2'h2;
    localparam [1:0] ST_GATED = 2'h3;

    assign wr_en              = reg_wr;
    assign counter_enable     = power_control_1_q[`BIT_COUNTER_ENABLE];
    assign counter_source_sel = power_control_1_q[`BIT_COUNTER_SOURCE_SEL];
    assign global_irq_enable  = int_enable_0_q[`BIT_GLOBAL_IRQ_ENABLE];

    assign window_enable      = power_control_1_q[`BIT_WINDOW_ENABLE];
    assign high_threshold_sel = threshold_select_q[7:4];
    assign low_threshold_sel  = threshold_select_q[3:0];
    assign window_input_sel   = window_input_sel_q;

    // Two-stage synchronisers for every asynchronous level
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= {multifunc_cmp_out, ext_count_input,
                        low_cmp_raw, high_cmp_raw};
            sync2_q <= sync1_q;
        end
    end

    // High and low comparators read as off while powered down
    assign high_cmp_out = sync2_q[0] & window_enable;
    assign low_cmp_out  = sync2_q[1] & window_enable;
    assign ext_sync     = sync2_q[2];
    assign mfc_sync     = sync2_q[3];

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            window_out_q <= 1'b0;
        end else if (!window_enable) begin
            window_out_q <= 1'b0;
        end else if (high_cmp_out) begin
            window_out_q <= 1'b1;
        end else if (low_cmp_out) begin
            window_out_q <= 1'b0;
        end
    end

    assign meas_cmp_signal = meas_cmp_source_sel_q ? mfc_sync : window_out_q;
    assign test_signal = counter_source_sel ? ext_sync : meas_cmp_signal;
    assign test_rise   = test_signal & ~test_prev_q;

    assign gate_sum   = {1'b0, gate_counter_q} + {{CW{1'b0}}, 1'b1};
    assign cycle_sum  = {1'b0, cycle_counter_q} + {{CW{1'b0}}, 1'b1};
    assign running    = (meas_state_q == ST_COUNT) |
                        (meas_state_q == ST_GATED);
    assign gate_done  = (meas_state_q == ST_GATED);
    assign gate_wrap  = running & gate_sum[CW];
    assign cycle_wrap = running & test_rise & cycle_sum[CW];
    assign stop_now   = running & (gate_done | gate_wrap) & test_rise;

    always @* begin
        meas_state_d = meas_state_q;
        case (meas_state_q)
            ST_ARMED: begin
                if (test_rise) begin
                    meas_state_d = ST_COUNT;
                end
            end
            ST_COUNT: begin
                // Wrap on a rising edge stops at once
                if (stop_now) begin
                    meas_state_d = ST_STOP;
                end else if (gate_wrap) begin
                    meas_state_d = ST_GATED;
                end
            end
            ST_GATED: begin
                if (stop_now) begin
                    meas_state_d = ST_STOP;
                end
            end
            default: begin
                meas_state_d = ST_STOP;
            end
        endcase
        if (!counter_enable) begin
            meas_state_d = ST_ARMED;
        end
    end

    // Stopped after reset; only a disable arms a new run
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meas_state_q <= ST_STOP;
        end else begin
            meas_state_q <= meas_state_d;
        end
    end

    // Measurement counters
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            gate_counter_q      <= `RESET_COUNT;
            cycle_counter_q     <= `RESET_COUNT;
            high_time_counter_q <= `RESET_COUNT;
            test_prev_q         <= 1'b0;
        end else begin
            test_prev_q <= test_signal;
            if (!counter_enable) begin
                gate_counter_q[7:0] <= 8'h00;
                cycle_counter_q     <= `RESET_COUNT;
                high_time_counter_q <= `RESET_COUNT;
                if (wr_en && reg_addr == `ADDR_GATE_UPPER) begin
                    gate_counter_q[23:16] <= reg_wdata;
                end
                if (wr_en && reg_addr == `ADDR_GATE_MIDDLE) begin
                    gate_counter_q[15:8] <= reg_wdata;
                end
            end else if (running) begin
                // gate on system clock
                // Runs past the wrap to give the final count
                gate_counter_q <= gate_sum[CW-1:0];
                if (test_rise) begin
                    cycle_counter_q <= cycle_sum[CW-1:0];
                end
                if (test_signal) begin
                    high_time_counter_q <= high_time_counter_q + 24'h000001;
                end
            end
        end
    end

    assign window_change = window_out_q ^ window_prev_q;
    assign high_change   = high_cmp_out ^ high_prev_q;
    assign low_change    = low_cmp_out ^ low_prev_q;

    // Registers and sticky flags; a set wins over a clear
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            int_enable_0_q        <= `RESET_BYTE;
            int_enable_2_q        <= `RESET_BYTE;
            measure_done_flag_q   <= 1'b0;
            window_out_flag_q     <= 1'b0;
            high_out_flag_q       <= 1'b0;
            low_out_flag_q        <= 1'b0;
            cycle_overflow_flag_q <= 1'b0;
            power_control_1_q     <= `RESET_BYTE;
            threshold_select_q    <= `RESET_BYTE;
            window_input_sel_q    <= 3'h0;
            meas_cmp_source_sel_q <= 1'b0;
            window_prev_q         <= 1'b0;
            high_prev_q           <= 1'b0;
            low_prev_q            <= 1'b0;
        end else begin
            window_prev_q <= window_out_q;
            high_prev_q   <= high_cmp_out;
            low_prev_q    <= low_cmp_out;
            if (wr_en) begin
                case (reg_addr)
                    `ADDR_INT_ENABLE_0:     int_enable_0_q     <= reg_wdata;
                    `ADDR_INT_ENABLE_2:     int_enable_2_q     <= reg_wdata;
                    `ADDR_POWER_CONTROL_1:  power_control_1_q  <= reg_wdata;
                    `ADDR_THRESHOLD_SELECT: threshold_select_q <= reg_wdata;
                    `ADDR_INPUT_SELECT: begin
                        window_input_sel_q    <= reg_wdata[7:5];
                        meas_cmp_source_sel_q <=
                            reg_wdata[`BIT_MEAS_CMP_SOURCE];
                    end
                    `ADDR_INT_FLAG_0: begin
                        measure_done_flag_q <=
                            reg_wdata[`BIT_MEASURE_DONE_FLAG];
                    end
                    `ADDR_INT_FLAG_2: begin
                        window_out_flag_q     <= reg_wdata[6];
                        high_out_flag_q       <= reg_wdata[5];
                        low_out_flag_q        <= reg_wdata[4];
                        cycle_overflow_flag_q <=
                            reg_wdata[`BIT_CYCLE_OVERFLOW];
                    end
                    default: begin
                    end
                endcase
            end
            if (stop_now) begin
                measure_done_flag_q <= 1'b1;
            end
            if (window_change) begin
                window_out_flag_q <= 1'b1;
            end
            if (high_change) begin
                high_out_flag_q <= 1'b1;
            end
            if (low_change) begin
                low_out_flag_q <= 1'b1;
            end
            if (cycle_wrap) begin
                cycle_overflow_flag_q <= 1'b1;
            end else if (!counter_enable) begin
                cycle_overflow_flag_q <= 1'b0;
            end
        end
    end

    assign measure_done_irq = global_irq_enable &
        ((measure_done_flag_q & int_enable_0_q[`BIT_MEASURE_DONE_IE]) |
         (cycle_overflow_flag_q & int_enable_2_q[`BIT_CYCLE_OVERFLOW]));
    assign window_irq = global_irq_enable &
        ((window_out_flag_q & int_enable_2_q[`BIT_WINDOW_OUT_IE]) |
         (high_out_flag_q & int_enable_2_q[`BIT_HIGH_OUT_IE]) |
         (low_out_flag_q & int_enable_2_q[`BIT_LOW_OUT_IE]));

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= `RESET_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADDR_INT_ENABLE_0:     reg_rdata <= int_enable_0_q;
                `ADDR_INT_ENABLE_2:     reg_rdata <= {1'b0,
                                                      int_enable_2_q[6:0]};
                `ADDR_INT_FLAG_0:       reg_rdata <= {4'h0,
                                                      measure_done_flag_q,
                                                      3'h0};
                `ADDR_INT_FLAG_2:       reg_rdata <= {1'b0,
                                                      window_out_flag_q,
                                                      high_out_flag_q,
                                                      low_out_flag_q,
                                                      cycle_overflow_flag_q,
                                                      3'h0};
                `ADDR_POWER_CONTROL_1:  reg_rdata <= power_control_1_q;
                `ADDR_THRESHOLD_SELECT: reg_rdata <= threshold_select_q;
                `ADDR_INPUT_SELECT:     reg_rdata <= {window_input_sel_q,
                                                      meas_cmp_source_sel_q,
                                                      window_out_q,
                                                      high_cmp_out,
                                                      low_cmp_out,
                                                      counter_source_sel};
                `ADDR_GATE_UPPER:       reg_rdata <= gate_counter_q[23:16];
                `ADDR_GATE_MIDDLE:      reg_rdata <= gate_counter_q[15:8];
                `ADDR_GATE_LOWER:       reg_rdata <= gate_counter_q[7:0];
                `ADDR_CYCLE_UPPER:      reg_rdata <= cycle_counter_q[23:16];
                `ADDR_CYCLE_MIDDLE:     reg_rdata <= cycle_counter_q[15:8];
                `ADDR_CYCLE_LOWER:      reg_rdata <= cycle_counter_q[7:0];
                `ADDR_HIGH_UPPER:       reg_rdata <=
                                            high_time_counter_q[23:16];
                `ADDR_HIGH_MIDDLE:      reg_rdata <= high_time_counter_q[15:8];
                `ADDR_HIGH_LOWER:       reg_rdata <= high_time_counter_q[7:0];
                default:                reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule

// ### hdl/freq_counter_regs.vh
// Purpose: register offsets, bit positions and reset values
// Assumes: byte-wide register port, byte addresses
// Notes:   included by freq_counter.v only
`ifndef FREQ_COUNTER_REGS_VH
`define FREQ_COUNTER_REGS_VH

`define ADDR_INT_ENABLE_0      8'h23
`define ADDR_INT_ENABLE_2      8'h25
`define ADDR_INT_FLAG_0        8'h26
`define ADDR_INT_FLAG_2        8'h28
`define ADDR_POWER_CONTROL_1   8'h33
`define ADDR_THRESHOLD_SELECT  8'h44
`define ADDR_INPUT_SELECT      8'h45
`define ADDR_GATE_UPPER        8'h4C
`define ADDR_GATE_MIDDLE       8'h4D
`define ADDR_GATE_LOWER        8'h4E
`define ADDR_CYCLE_UPPER       8'h4F
`define ADDR_CYCLE_MIDDLE      8'h50
`define ADDR_CYCLE_LOWER       8'h51
`define ADDR_HIGH_UPPER        8'h52
`define ADDR_HIGH_MIDDLE       8'h53
`define ADDR_HIGH_LOWER        8'h54

`define BIT_GLOBAL_IRQ_ENABLE  7
`define BIT_MEASURE_DONE_IE    3
`define BIT_MEASURE_DONE_FLAG  3
`define BIT_WINDOW_OUT_IE      6
`define BIT_HIGH_OUT_IE        5
`define BIT_LOW_OUT_IE         4
`define BIT_CYCLE_OVERFLOW     3
`define BIT_WINDOW_ENABLE      6
`define BIT_COUNTER_SOURCE_SEL 5
`define BIT_COUNTER_ENABLE     4
`define BIT_MEAS_CMP_SOURCE    4
`define BIT_WINDOW_OUT_STATUS  3
`define BIT_HIGH_OUT_STATUS    2
`define BIT_LOW_OUT_STATUS     1
`define BIT_COUNTER_INPUT_SRC  0

`define RESET_BYTE             8'h00
`define RESET_COUNT            24'h000000

`endif

// ### verification/fc_checker_sva.sv
// Purpose: port-level checks of the frequency counter
// Assumes: one clock, register writes take effect next cycle
// Notes:   helpers mirror only the enable and global irq bits
module fc_checker #(
    parameter CW = 24
) (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       reset_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Controls and requests
    input wire logic       window_enable,
    input wire logic [3:0] high_threshold_sel,
    input wire logic [3:0] low_threshold_sel,
    input wire logic [2:0] window_input_sel,
    input wire logic       measure_done_irq,
    input wire logic       window_irq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] wd_q;
    logic       en_q, en_prev_q, gie_q;

    default clocking dclk @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // Two disabled cycles so the clear has surely landed
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wd_q      <= 8'h00;
            en_q      <= 1'b0;
            en_prev_q <= 1'b0;
            gie_q     <= 1'b0;
        end else begin
            wd_q      <= reg_wdata;
            en_prev_q <= en_q;
            if (reg_wr && reg_addr == 8'h33)
                en_q <= reg_wdata[4];
            if (reg_wr && reg_addr == 8'h23)
                gie_q <= reg_wdata[7];
        end
    end

    property p_thr;
        reg_wr && reg_addr == 8'h44 |=>
            {high_threshold_sel, low_threshold_sel} == wd_q;
    endproperty
    a_thr: assert property (p_thr) else $error("threshold select");
    property p_insel;
        reg_wr && reg_addr == 8'h45 |=> window_input_sel == wd_q[7:5];
    endproperty
    a_insel: assert property (p_insel) else $error("input select");
    property p_wen;
        reg_wr && reg_addr == 8'h33 |=> window_enable == wd_q[6];
    endproperty
    a_wen: assert property (p_wen) else $error("window enable");
    property p_unmapped;
        reg_rd && reg_addr == 8'h10 |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped");
    property p_off_zero;
        reg_rd && reg_addr >= 8'h4E && reg_addr <= 8'h54 && !en_q
            && !en_prev_q |=> reg_rdata == 8'h00;
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("not clear");
    property p_done_gie;
        measure_done_irq |-> gie_q;
    endproperty
    a_done_gie: assert property (p_done_gie) else $error("done irq");
    property p_win_gie;
        window_irq |-> gie_q;
    endproperty
    a_win_gie: assert property (p_win_gie) else $error("window irq");
    property p_rd_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data");
endmodule

bind freq_counter fc_checker #(.CW(CW)) u_fc_checker (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .window_enable(window_enable),
    .high_threshold_sel(high_threshold_sel),
    .low_threshold_sel(low_threshold_sel),
    .window_input_sel(window_input_sel),
    .measure_done_irq(measure_done_irq), .window_irq(window_irq)
);

// ### verification/wave_source.sv
// Purpose: periodic signal under test
// Assumes: shape given in whole 5 ns clock periods
// Notes:   idles low outside a run
module wave_source (
    // Shape and gating
    input wire logic       run,
    input wire logic [7:0] per,
    input wire logic [7:0] hi,
    // Signal under test
    output logic           wave
);
    timeunit 1ns;
    timeprecision 100ps;
    // Offset keeps edges clear of the sampling edge
    initial begin
        wave = 1'b0;
        #1.7;
        forever begin
            if (run) begin
                wave = 1'b1;
                #(hi * 5);
                wave = 1'b0;
                #((per - hi) * 5);
            end else begin
                #5;
            end
        end
    end
endmodule

// ### verification/testbench.sv
// Purpose: self-checking bench for the frequency counter
// Assumes: 200 MHz clock, gate preload FFFF00
// Notes:   short preload keeps each gate at 256 clocks
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk, reset_n, reg_wr, reg_rd, run, hc, lc, wave;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, wave_per, wave_hi;
    logic [3:0]  high_threshold_sel, low_threshold_sel;
    logic [2:0]  window_input_sel;
    logic        window_enable, measure_done_irq, window_irq;
    logic [1:0]  route;
    logic [31:0] seed, rv;
    int          n_mismatch, comparisons, cyc, p;
    // Periods whose multiples keep clear of the 256-clock wrap
    int          periods[11] = '{7, 9, 10, 11, 12, 13, 14, 18, 19, 20, 21};
    logic [7:0]  rst_addr[7] = '{8'h23, 8'h25, 8'h26, 8'h28, 8'h33,
                                 8'h44, 8'h45};

    freq_counter #(.CW(24)) u_freq_counter (
        .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ext_count_input(route == 2'd0 && wave),
        .high_cmp_raw(route == 2'd2 ? wave : hc),
        .low_cmp_raw(route == 2'd2 ? !wave : lc),
        .multifunc_cmp_out(route == 2'd1 && wave),
        .window_enable(window_enable),
        .high_threshold_sel(high_threshold_sel),
        .low_threshold_sel(low_threshold_sel),
        .window_input_sel(window_input_sel),
        .measure_done_irq(measure_done_irq), .window_irq(window_irq)
    );
    wave_source u_wave_source (.run(run), .per(wave_per), .hi(wave_hi),
                               .wave(wave));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int n_per(input int pp);
        return 256 / pp + 1;
    endfunction
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input int lo, hv,
                       input logic [23:0] got);
        comparisons++;
        if ((got >= lo && got <= hv) !== 1'b1) begin
            n_mismatch++;
            $display("wrong value %s expected %0d..%0d seen %0d",
                     nm, lo, hv, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input int lo, hv);
        logic [7:0] d;
        rd(a, d);
        chk($sformatf("byte %h", a), lo, hv, {16'h0000, d});
    endtask
    task automatic rdc24(input logic [7:0] a, input int lo, hv);
        logic [7:0] b2, b1, b0;
        rd(a, b2);
        rd(a + 8'h01, b1);
        rd(a + 8'h02, b0);
        chk($sformatf("count %h", a), lo, hv, {b2, b1, b0});
    endtask
    task automatic step(input logic h, l, input logic [7:0] st);
        @(posedge core_clk);
        hc <= h;
        lc <= l;
        repeat (6) @(posedge core_clk);
        rdc(8'h45, (rv[7:0] & 8'hE0) | st, (rv[7:0] & 8'hE0) | st);
    endtask
    task automatic meas(input logic [1:0] r, input int pp, h);
        logic [7:0] cfg;
        int         n, k, fin;
        cfg = (r == 2'd0) ? 8'h20 : ((r == 2'd2) ? 8'h40 : 8'h00);
        n = n_per(pp);
        // Final gate count once whole periods cover the gate
        fin = n * pp - (32'h0100_0000 - 32'h00FF_FF00);
        @(posedge core_clk);
        route <= r;
        wave_per <= pp[7:0];
        wave_hi <= h[7:0];
        wr(8'h33, cfg);
        wr(8'h45, {3'b000, r == 2'd1, 4'h0});
        wr(8'h4C, 8'hFF);
        wr(8'h4D, 8'hFF);
        rdc(8'h4C, 8'hFF, 8'hFF);
        wr(8'h23, 8'h88);
        run <= 1'b1;
        wr(8'h33, cfg | 8'h10);
        wr(8'h4C, 8'h12);
        // Sampled away from the edge that moves the flag
        for (k = 0; k < 2000 && measure_done_irq !== 1'b1; k++)
            @(negedge core_clk);
        chk("done irq", 1, 1, measure_done_irq);
        run <= 1'b0;
        rdc24(8'h4C, fin - 2, fin + 2);
        rdc24(8'h4F, n, n);
        rdc24(8'h52, n * h - 1, n * h + 1);
        rdc(8'h26, 8'h08, 8'h08);
        wr(8'h26, 8'h00);
        wr(8'h33, cfg);
        rdc(8'h4E, 0, 0);
        rdc24(8'h4F, 0, 0);
        rdc24(8'h52, 0, 0);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Whole run needs about 2100 cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        {reset_n, reg_wr, reg_rd, run, hc, lc} = 6'b000000;
        {reg_addr, reg_wdata, wave_per, wave_hi} = 32'h0000_0A05;
        route = 2'd0;
        seed = 32'd11;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        foreach (rst_addr[i])
            rdc(rst_addr[i], 0, 0);
        rdc(8'h10, 0, 0);
        rv = xs();
        wr(8'h44, rv[7:0]);
        #1 chk("thr", rv[7:0], rv[7:0],
               {high_threshold_sel, low_threshold_sel});
        rdc(8'h44, rv[7:0], rv[7:0]);
        wr(8'h45, rv[7:0] & 8'hE0);
        #1 chk("insel", rv[7:5], rv[7:5], window_input_sel);
        wr(8'h33, 8'h40);
        #1 chk("wen", 1, 1, window_enable);
        step(1'b1, 1'b0, 8'h0C);
        step(1'b0, 1'b0, 8'h08);
        step(1'b0, 1'b1, 8'h02);
        wr(8'h25, 8'h40);
        wr(8'h23, 8'h80);
        #1 chk("wirq", 1, 1, window_irq);
        wr(8'h33, 8'h00);
        step(1'b1, 1'b0, 8'h00);
        wr(8'h28, 8'h00);
        #1 chk("wirq", 0, 0, window_irq);
        wr(8'h25, 8'h08);
        wr(8'h33, 8'h10);
        wr(8'h28, 8'h08);
        #1 chk("oirq", 1, 1, measure_done_irq);
        rdc(8'h28, 8'h08, 8'h08);
        wr(8'h33, 8'h00);
        rdc(8'h28, 0, 0);
        #1 chk("oirq", 0, 0, measure_done_irq);
        meas(2'd0, 7, 2);
        meas(2'd1, 21, 19);
        meas(2'd2, 10, 5);
        repeat (3) begin
            rv = xs();
            p = periods[rv[11:8] % 11];
            meas(2'(rv % 3), p, 2 + rv[23:16] % (p - 3));
        end
        final_report();
    end
endmodule
